// [core/awt_pkg.sv]
// package: register map, field layout, types for area-0 wait timing control
package awt_pkg;

  // ==========================================================================
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] AWT_OFS_WAIT_CTRL = 8'h00;
  localparam logic [7:0] AWT_OFS_BUS_CTRL = 8'h04;
  localparam logic [7:0] AWT_OFS_STATUS = 8'h08;

  // ==========================================================================
  // area0_wait_control field positions
  localparam int AWT_SETUP_LSB = 11;
  localparam int AWT_WAIT_LSB = 7;
  localparam int AWT_MASK_BIT = 6;
  localparam int AWT_HOLD_LSB = 0;
  // area_bus_control memory type field
  localparam int AWT_TYPE_LSB = 12;
  // status bits
  localparam int AWT_ST_BUSY = 0;
  localparam int AWT_ST_BAD_WAIT = 1;
  localparam int AWT_ST_BAD_TYPE = 2;

  // ==========================================================================
  // reset values and writable masks
  localparam logic [1:0] AWT_SETUP_RST = 2'h0;
  localparam logic [3:0] AWT_WAIT_RST = 4'hA;
  localparam logic AWT_MASK_RST = 1'b0;
  localparam logic [1:0] AWT_HOLD_RST = 2'h0;
  localparam logic [3:0] AWT_TYPE_RST = 4'h0;
  localparam logic [31:0] AWT_WAIT_CTRL_WMASK = 32'h0000_1FC3;

  // ==========================================================================
  // memory type codes served by this layout
  localparam logic [3:0] AWT_MT_NORMAL = 4'h0;
  localparam logic [3:0] AWT_MT_BYTESEL = 4'h3;

  // ==========================================================================
  // timing: one external bus cycle lasts two clk_sys cycles (40 ns each),
  // so a half bus cycle is exactly one clk_sys cycle
  localparam int AWT_CLK_NS = 40;
  localparam int AWT_HALF_CYC = 1;
  localparam int AWT_FULL_CYC = 2 * AWT_HALF_CYC;
  localparam int AWT_CNT_W = 6;

  // ==========================================================================
  // external bus pin bundle
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic we_n;
    logic [1:0] be_n;
    logic [19:0] addr;
    logic [15:0] dout;
    logic doe;
  } awt_ebus_t;

  // internal access request
  typedef struct packed {
    logic write;
    logic [1:0] be;
    logic [19:0] addr;
    logic [15:0] wdata;
  } awt_req_t;

endpackage : awt_pkg

// [core/awt_wait_decode.sv]
// file: maps the access-wait code to a count of bus wait cycles
`timescale 1ns/1ns
module awt_wait_decode
  import awt_pkg::*;
(
  // code in
  input wire logic [3:0] code,
  // decoded
  output logic [4:0] cycles,
  output logic prohibited
);

  // ==========================================================================
  // decode
  always_comb
  begin
    prohibited = 1'b0;
    case (code)
      4'h7: cycles = 5'h08;
      4'h8: cycles = 5'h0A;
      4'h9: cycles = 5'h0C;
      4'hA: cycles = 5'h0E;
      4'hB: cycles = 5'h12;
      4'hC: cycles = 5'h18;
      4'hD, 4'hE, 4'hF:
      begin
        // prohibited codes fall back to the longest wait, the safe side
        cycles = 5'h18;
        prohibited = 1'b1;
      end
      default: cycles = {2'h0, code[2:0]};
    endcase
  end

endmodule : awt_wait_decode

// [core/awt_dly_cnt.sv]
// file: loadable down counter timing one phase of an external access
`timescale 1ns/1ns
module awt_dly_cnt
  import awt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [awt_pkg::AWT_CNT_W-1:0] load_val,
  // state
  output logic zero
);

  logic [AWT_CNT_W-1:0] cnt_q;
  logic [AWT_CNT_W-1:0] cnt_d;

  // ==========================================================================
  // count
  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = load_val;
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign zero = (cnt_q == '0);

endmodule : awt_dly_cnt

// [core/awt_area0_ctrl.sv]
// file: area-0 wait timing control with AHB-Lite registers and bus engine
`timescale 1ns/1ns
// How it works
// - wait register layout used only when memory type selects it.
// - bits 12:11 set address/select to strobe delay, 0.5 to 3.5 cycles.
// - bits 10:7 set wait cycles: 0-6, then 8,10,12,14,18,24.
// - access-wait field resets to 1010, fourteen wait cycles.
// - bit 6 set ignores external wait, clear honours it; resets clear.
// - bits 1:0 set strobe to address/select release delay; reset 00.
// - reserved bits 31:13 and 5:2 read zero; software writes zero.
// - memory type 0000 normal, 0011 byte-select SRAM, both this layout.
module awt_area0_ctrl
  import awt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // internal access port
  input wire logic req_valid,
  input wire awt_pkg::awt_req_t req,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_err,
  output logic [15:0] resp_rdata,
  // external bus
  output awt_pkg::awt_ebus_t ebus,
  input wire logic [15:0] ebus_din,
  input wire logic ext_wait_n
);

  typedef enum logic [2:0] {
    AWT_IDLE,
    AWT_SETUP,
    AWT_STROBE,
    AWT_EXTW,
    AWT_HOLD
  } awt_state_t;

  // ==========================================================================
  // register state
  logic [1:0] setup_q, setup_d;
  logic [3:0] wait_q, wait_d;
  logic mask_q, mask_d;
  logic [1:0] hold_q, hold_d;
  logic [3:0] type_q, type_d;
  logic bad_type_q, bad_type_d;
  // ahb pipeline
  logic dp_wr_q, dp_wr_d;
  logic dp_rd_q, dp_rd_d;
  logic [7:0] dp_addr_q, dp_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  // engine
  awt_state_t state_q, state_d;
  awt_req_t cur_q, cur_d;
  awt_ebus_t ebus_q, ebus_d;
  logic req_ready_q, req_ready_d;
  logic resp_valid_q, resp_valid_d;
  logic resp_err_q, resp_err_d;
  logic [15:0] resp_rdata_q, resp_rdata_d;
  // helpers
  logic [4:0] wait_cycles;
  logic wait_bad;
  logic cnt_zero;
  logic cnt_load;
  logic [AWT_CNT_W-1:0] cnt_val;
  logic layout_ok;
  logic ap_take;
  logic [31:0] wait_rd;
  logic [31:0] rd_mux;

  // ==========================================================================
  // submodules
  awt_wait_decode u_dec (
    .code(wait_q),
    .cycles(wait_cycles),
    .prohibited(wait_bad)
  );

  awt_dly_cnt u_cnt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(cnt_load),
    .load_val(cnt_val),
    .zero(cnt_zero)
  );

  // ==========================================================================
  // register read view
  always_comb
  begin
    wait_rd = '0;
    wait_rd[AWT_SETUP_LSB +: 2] = setup_q;
    wait_rd[AWT_WAIT_LSB +: 4] = wait_q;
    wait_rd[AWT_MASK_BIT] = mask_q;
    wait_rd[AWT_HOLD_LSB +: 2] = hold_q;
    rd_mux = '0;
    if (dp_addr_q == AWT_OFS_WAIT_CTRL)
      rd_mux = wait_rd;
    else if (dp_addr_q == AWT_OFS_BUS_CTRL)
      rd_mux[AWT_TYPE_LSB +: 4] = type_q;
    else if (dp_addr_q == AWT_OFS_STATUS)
    begin
      rd_mux[AWT_ST_BUSY] = (state_q != AWT_IDLE);
      rd_mux[AWT_ST_BAD_WAIT] = wait_bad;
      rd_mux[AWT_ST_BAD_TYPE] = bad_type_q;
    end
  end

  // ==========================================================================
  // ahb-lite slave: writes zero-wait, reads one wait state so the data
  // always follows a write that is still in its data phase
  assign ap_take = hsel && hready && htrans[1];

  always_comb
  begin
    setup_d = setup_q;
    wait_d = wait_q;
    mask_d = mask_q;
    hold_d = hold_q;
    type_d = type_q;
    dp_wr_d = ap_take && hwrite;
    dp_rd_d = 1'b0;
    dp_addr_d = dp_addr_q;
    hrdata_d = hrdata_q;
    hreadyout_d = 1'b1;
    if (ap_take)
      dp_addr_d = haddr[7:0];
    if (ap_take && !hwrite)
    begin
      dp_rd_d = 1'b1;
      hreadyout_d = 1'b0;
    end
    if (dp_rd_q)
      hrdata_d = rd_mux;
    if (dp_wr_q)
    begin
      if (dp_addr_q == AWT_OFS_WAIT_CTRL)
      begin
        // reserved bits are simply not stored
        setup_d = hwdata[AWT_SETUP_LSB +: 2];
        wait_d = hwdata[AWT_WAIT_LSB +: 4];
        mask_d = hwdata[AWT_MASK_BIT];
        hold_d = hwdata[AWT_HOLD_LSB +: 2];
      end
      else if (dp_addr_q == AWT_OFS_BUS_CTRL)
        type_d = hwdata[AWT_TYPE_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      setup_q <= AWT_SETUP_RST;
      wait_q <= AWT_WAIT_RST;
      mask_q <= AWT_MASK_RST;
      hold_q <= AWT_HOLD_RST;
      type_q <= AWT_TYPE_RST;
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      setup_q <= setup_d;
      wait_q <= wait_d;
      mask_q <= mask_d;
      hold_q <= hold_d;
      type_q <= type_d;
      dp_wr_q <= dp_wr_d;
      dp_rd_q <= dp_rd_d;
      dp_addr_q <= dp_addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= hreadyout_d;
    end
  end

  // ==========================================================================
  // external access engine; phases counted in half bus cycles
  assign layout_ok = (type_q == AWT_MT_NORMAL) ||
                     (type_q == AWT_MT_BYTESEL);

  always_comb
  begin
    state_d = state_q;
    cur_d = cur_q;
    cnt_load = 1'b0;
    cnt_val = '0;
    resp_valid_d = 1'b0;
    resp_err_d = 1'b0;
    resp_rdata_d = resp_rdata_q;
    bad_type_d = bad_type_q;
    case (state_q)
      AWT_IDLE:
        if (req_valid && req_ready_q)
        begin
          if (!layout_ok)
          begin
            // other memory types need another layout: refuse the access
            resp_valid_d = 1'b1;
            resp_err_d = 1'b1;
            bad_type_d = 1'b1;
          end
          else
          begin
            cur_d = req;
            bad_type_d = 1'b0;
            state_d = AWT_SETUP;
            cnt_load = 1'b1;
            // 0.5 + n cycles -> 2n half cycles after this one
            cnt_val = AWT_CNT_W'({setup_q, 1'b0});
          end
        end
      AWT_SETUP:
        if (cnt_zero)
        begin
          state_d = AWT_STROBE;
          cnt_load = 1'b1;
          // one base bus cycle plus the programmed waits
          cnt_val = AWT_CNT_W'({wait_cycles, 1'b0} +
                    6'(AWT_FULL_CYC - 1));
        end
      AWT_STROBE, AWT_EXTW:
        if (cnt_zero)
        begin
          // mask checked even for zero programmed waits
          if (!mask_q && !ext_wait_n)
            state_d = AWT_EXTW;
          else
          begin
            resp_rdata_d = ebus_din;
            state_d = AWT_HOLD;
            cnt_load = 1'b1;
            cnt_val = AWT_CNT_W'({hold_q, 1'b0});
          end
        end
      AWT_HOLD:
        if (cnt_zero)
        begin
          state_d = AWT_IDLE;
          resp_valid_d = 1'b1;
        end
      default: state_d = AWT_IDLE;
    endcase
  end

  // pins follow the next state so they leave flip-flops in step with it
  always_comb
  begin
    ebus_d.cs_n = (state_d == AWT_IDLE);
    ebus_d.addr = (state_d == AWT_IDLE) ? ebus_q.addr : cur_d.addr;
    ebus_d.rd_n = !(((state_d == AWT_STROBE) || (state_d == AWT_EXTW)) &&
                    !cur_d.write);
    ebus_d.we_n = !(((state_d == AWT_STROBE) || (state_d == AWT_EXTW)) &&
                    cur_d.write);
    ebus_d.be_n = ((state_d == AWT_STROBE) || (state_d == AWT_EXTW)) ?
                  ~cur_d.be : 2'h3;
    // write data held from setup through hold
    ebus_d.doe = (state_d != AWT_IDLE) && cur_d.write;
    ebus_d.dout = cur_d.wdata;
    req_ready_d = (state_d == AWT_IDLE) && !resp_valid_d;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= AWT_IDLE;
      cur_q <= '0;
      ebus_q <= '{cs_n: 1'b1, rd_n: 1'b1, we_n: 1'b1, be_n: 2'h3,
                  addr: 20'h0_0000, dout: 16'h0000, doe: 1'b0};
      req_ready_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_err_q <= 1'b0;
      resp_rdata_q <= 16'h0000;
      bad_type_q <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cur_q <= cur_d;
      ebus_q <= ebus_d;
      req_ready_q <= req_ready_d;
      resp_valid_q <= resp_valid_d;
      resp_err_q <= resp_err_d;
      resp_rdata_q <= resp_rdata_d;
      bad_type_q <= bad_type_d;
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // outputs
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign req_ready = req_ready_q;
  assign resp_valid = resp_valid_q;
  assign resp_err = resp_err_q;
  assign resp_rdata = resp_rdata_q;
  assign ebus = ebus_q;

endmodule : awt_area0_ctrl

// [verif/awt_area0_ctrl_assertions.sv]
// checker: timing relations of the area-0 external bus
`timescale 1ns/1ns
module awt_area0_ctrl_assertions
  import awt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  // access port and bus
  input wire logic resp_valid,
  input wire logic resp_err,
  input wire awt_pkg::awt_ebus_t ebus
);
  // ==========================================================================
  // shadow of the wait register and a phase length counter
  logic ap_q;
  logic [12:0] wc_q;
  logic cs_q;
  logic st_q;
  logic [7:0] n_q;
  logic st;
  assign st = !ebus.rd_n || !ebus.we_n;
  // prohibited codes act as the longest setting
  function automatic int wt(input logic [3:0] c);
    if (c < 4'h7)
      return int'(c);
    if (c < 4'hB)
      return 2 * int'(c) - 6;
    return (c == 4'hB) ? 18 : 24;
  endfunction : wt
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ap_q <= 1'b0;
      wc_q <= 13'h0500;
      cs_q <= 1'b1;
      st_q <= 1'b0;
      n_q <= 8'h00;
    end
    else
    begin
      ap_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      if (ap_q)
        wc_q <= hwdata[12:0];
      cs_q <= ebus.cs_n;
      st_q <= st;
      n_q <= (ebus.cs_n != cs_q || st != st_q) ? 8'h01 : n_q + 8'h01;
    end
  end
  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_SETUP: assert property (
    st && !st_q |-> n_q == 2 * wc_q[12:11] + 1)
    else $error("setup length wrong");
  AST_STRB_EXACT: assert property (
    !st && st_q && wc_q[6] |-> n_q == 2 + 2 * wt(wc_q[10:7]))
    else $error("strobe length wrong");
  AST_STRB_MIN: assert property (!st && st_q
    |-> n_q >= 2 + 2 * wt(wc_q[10:7])) else $error("strobe too short");
  AST_HOLD: assert property (
    ebus.cs_n && !cs_q |-> n_q == 2 * wc_q[1:0] + 1)
    else $error("hold length wrong");
  AST_IDLE: assert property (ebus.cs_n |-> ebus.rd_n && ebus.we_n)
    else $error("strobe outside select");
  AST_DOE: assert property (!ebus.we_n |-> ebus.doe)
    else $error("write data not driven");
  AST_ERR: assert property (resp_err |-> resp_valid && ebus.cs_n)
    else $error("refusal touched the bus");
  AST_RD_WAIT: assert property (
    hsel && hready && htrans[1] && !hwrite |=> s_rd_answer)
    else $error("read answer timing wrong");
endmodule : awt_area0_ctrl_assertions

bind awt_area0_ctrl awt_area0_ctrl_assertions u_chk (.clk_sys, .nrst, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .resp_valid,
  .resp_err, .ebus);

// [verif/awt_sram_model.sv]
// model: asynchronous sram with a programmable wait request
`timescale 1ns/1ns
module awt_sram_model
  import awt_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // bus from the controller, wait length from the testbench
  input wire awt_pkg::awt_ebus_t ebus,
  input wire logic [3:0] wait_len,
  // answers
  output logic [15:0] ebus_din,
  output logic ext_wait_n
);
  // ==========================================================================
  // storage and wait request
  logic [15:0] mem [0:15];
  logic [15:0] last_q = 16'h0000;
  logic [3:0] w_q = 4'h0;
  logic st_q = 1'b0;
  logic sel;
  logic wr;
  assign sel = !ebus.cs_n && !ebus.rd_n;
  assign wr = !ebus.cs_n && !ebus.we_n;
  // released bus shows the inverse, so a late capture reads wrong data
  assign ebus_din = sel ? mem[ebus.addr[3:0]] : ~last_q;
  assign ext_wait_n = (w_q == 4'h0);
  always @(posedge clk_sys)
  begin
    if (sel)
      last_q <= mem[ebus.addr[3:0]];
    if (wr && !ebus.be_n[0])
      mem[ebus.addr[3:0]][7:0] <= ebus.dout[7:0];
    if (wr && !ebus.be_n[1])
      mem[ebus.addr[3:0]][15:8] <= ebus.dout[15:8];
    st_q <= !ebus.rd_n || !ebus.we_n;
    if ((!ebus.rd_n || !ebus.we_n) && !st_q)
      w_q <= wait_len;
    else if (w_q != 4'h0)
      w_q <= w_q - 4'h1;
  end
endmodule : awt_sram_model

// [verif/tb.sv]
// testbench: register and external access checks for area-0 timing
`timescale 1ns/1ns
module tb;
  import awt_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic req_valid = 1'b0;
  awt_req_t req = '0;
  logic req_ready;
  logic resp_valid;
  logic resp_err;
  logic [15:0] resp_rdata;
  awt_ebus_t ebus;
  logic [15:0] ebus_din;
  logic ext_wait_n;
  logic [3:0] wait_len = 4'h0;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic q_err;
  logic [15:0] q_dat;
  int sc;
  int wt [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
  always #20 clk_sys = ~clk_sys;
  awt_area0_ctrl DUT (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .req_valid, .req, .req_ready, .resp_valid, .resp_err, .resp_rdata,
    .ebus, .ebus_din, .ext_wait_n);
  awt_sram_model u_mem (.clk_sys, .ebus, .wait_len, .ebus_din, .ext_wait_n);
  // ==========================================================================
  // report and compare
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  // ==========================================================================
  // ahb-lite master
  task automatic tick_rdy;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 50)
    begin
      miscompares++;
      finish_test;
    end
  endtask : tick_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    tick_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    tick_rdy;
    rd = hrdata;
  endtask : ahb
  // ==========================================================================
  // internal access, counting strobe cycles
  task automatic acc(input logic w, input logic [1:0] be, input logic [3:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    sc = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys);
    end
    req_valid <= 1'b1;
    req <= '{w, be, 20'(a), d};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // long waits plus external stretch stay well under this bound
    while (resp_valid !== 1'b1 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
      sc += int'(!ebus.rd_n || !ebus.we_n);
    end
    if (n >= 400)
    begin
      miscompares++;
      finish_test;
    end
    q_err = resp_err;
    q_dat = resp_rdata;
    @(posedge clk_sys);
  endtask : acc
  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    ahb(1'b0, AWT_OFS_WAIT_CTRL, 32'h0);
    chk("wait ctrl reset", 32'h0000_0500, rd);
    ahb(1'b1, AWT_OFS_BUS_CTRL, 32'h0);
    ahb(1'b1, AWT_OFS_WAIT_CTRL, 32'hFFFF_FE3F);
    ahb(1'b0, AWT_OFS_WAIT_CTRL, 32'h0);
    chk("reserved bits", 32'h0000_1E03, rd);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp okay", 32'h0, {31'h0, hresp});
    // prohibited wait codes 1101 to 1111 are never written
    for (int i = 0; i < 13; i++)
    begin
      ahb(1'b1, AWT_OFS_WAIT_CTRL, 32'(((i % 4) << 11) | (i << 7) | 32'h40
        | (3 - i % 4)));
      acc(1'b1, 2'h3, 4'(i), 16'hC300 + 16'(i));
      chk("strobe", 32'(2 + 2 * wt[i]), 32'(sc));
      acc(1'b0, 2'h3, 4'(i), 16'h0);
      chk("read data", 32'(16'hC300 + 16'(i)), {16'h0, q_dat});
    end
    // zero waits: the external wait must still stretch the strobe
    wait_len <= 4'h3;
    ahb(1'b1, AWT_OFS_WAIT_CTRL, 32'h0);
    acc(1'b0, 2'h3, 4'h0, 16'h0);
    chk("ext wait honoured", 32'h1, 32'(sc > 2));
    ahb(1'b1, AWT_OFS_WAIT_CTRL, 32'h40);
    acc(1'b0, 2'h3, 4'h0, 16'h0);
    chk("ext wait masked", 32'h2, 32'(sc));
    wait_len <= 4'h0;
    ahb(1'b1, AWT_OFS_BUS_CTRL, 32'h3000);
    ahb(1'b1, AWT_OFS_WAIT_CTRL, 32'h40);
    acc(1'b1, 2'h1, 4'h1, 16'hFFFF);
    acc(1'b0, 2'h3, 4'h1, 16'h0);
    chk("byte lane", 32'h0000_C3FF, {15'h0, q_err, q_dat});
    ahb(1'b1, AWT_OFS_BUS_CTRL, 32'h4000);
    acc(1'b0, 2'h3, 4'h1, 16'h0);
    chk("bad type refused", 32'h1, {31'h0, q_err});
    chk("bad type no strobe", 32'h0, 32'(sc));
    ahb(1'b0, AWT_OFS_STATUS, 32'h0);
    chk("status bad type", 32'h0000_0004, rd);
    ahb(1'b0, AWT_OFS_BUS_CTRL, 32'h0);
    chk("bus ctrl", 32'h0000_4000, rd);
    finish_test;
  end
endmodule : tb
